// ===== hdl/ulc_uart.sv
// Added by the designer: the AHB-Lite register port.
`timescale 1ns/1ns
`include "ulc_defs.svh"
// What this block does
// - Stick parity with even select: parity 0
// - Stick parity with odd select: parity 1
// - No stick: parity computed from data
// - Word length code selects five to eight
// - FIFO enable bit selects FIFO mode
// - FIFO off: one-byte holding register each way
// - Two-stop select sends two stop bits
// - Receiver checks only one stop bit
// - Even select makes ones count even
// - Even select clear makes ones count odd
// - Even select ignored without parity
// - Parity enable generates and checks parity
// - Parity disabled: no parity bit
// - Break drives line low after current character
// - Reset clears all but section enables
// - Module sends and receives only while enabled; break drives the line even when disabled
// - Disable lets current character finish
// - Line control write loads baud divisors
// - Bits eight, nine enable tx, rx sections
module ulc_uart
   import ulc_pkg::*;
#(
   parameter int DEPTH = 16
) (
   input  wire logic        CORE_CLK,
   input  wire logic        RST,
   input  wire logic        HSEL,
   input  wire logic [11:0] HADDR,
   input  wire logic [1:0]  HTRANS,
   input  wire logic        HWRITE,
   input  wire logic [2:0]  HSIZE,
   input  wire logic [31:0] HWDATA,
   input  wire logic        HREADY,
   output logic      [31:0] HRDATA,
   output logic             HREADYOUT,
   output logic             HRESP,
   input  wire logic        SERIAL_RX_PIN,
   output logic             SERIAL_TX_PIN
);
   // Software-visible registers, then the active divisor copies loaded from them.
   logic [7:0]  line_control;
   logic [9:0]  module_control;
   logic [15:0] integer_divisor;
   logic [5:0]  fractional_divisor;
   logic [15:0] act_int;
   logic [5:0]  act_frac;
   // Bus data-phase capture.
   logic        dp_wr, dp_rd;
   logic [11:0] dp_addr;
   // Transmit and receive buffers.
   logic [7:0]  tx_mem [DEPTH];
   logic [7:0]  rx_mem [DEPTH];
   logic [$clog2(DEPTH):0] tx_cnt, rx_cnt;
   logic [$clog2(DEPTH)-1:0] tx_rp, tx_wp, rx_rp, rx_wp;
   // Transmitter state.
   ulc_state_type tx_state;
   logic [7:0]  tx_shift;
   logic [2:0]  tx_bit;
   logic        tx_par, tx_fmt_two_stop_select, tx_stop2nd;
   logic [3:0]  tx_fmt_nbits;
   logic [1:0]  tx_fmt_par;
   logic [21:0] tx_tick;
   // Receiver state.
   ulc_state_type rx_state;
   logic [7:0]  rx_shift;
   logic [2:0]  rx_bit;
   logic [3:0]  rx_fmt_nbits;
   logic [1:0]  rx_fmt_par;
   logic        rx_fmt_pen, rx_par_err;
   logic [21:0] rx_tick;
   logic        rx_s1, rx_s2, err_pe, err_fe;
   wire logic bus_go = HSEL && HREADY && HTRANS[1];
   wire logic wr_lc  = dp_wr && dp_addr == `ULC_OFS_LCTL;
   wire logic wr_dat = dp_wr && dp_addr == `ULC_OFS_DATA;
   wire logic rd_dat = dp_rd && dp_addr == `ULC_OFS_DATA;
   wire logic [$clog2(DEPTH):0] cap =
      line_control[`ULC_LC_FEN] ? ($clog2(DEPTH)+1)'(DEPTH)
                                : ($clog2(DEPTH)+1)'(1);
   wire logic tx_full  = tx_cnt >= cap;
   wire logic rx_full  = rx_cnt >= cap;
   wire logic run_tx   = module_control[`ULC_MC_EN]
                         && module_control[`ULC_MC_TXE];
   wire logic run_rx   = module_control[`ULC_MC_EN]
                         && module_control[`ULC_MC_RXE];
   wire logic [21:0] bit_len = {act_int, act_frac};
   wire logic tx_bdone = tx_tick >= bit_len;
   wire logic rx_bdone = rx_tick >= bit_len;
   // Data bits per word: code plus five.
   function automatic logic [3:0] ulc_nbits(input logic [1:0] code);
      ulc_nbits = 4'(code) + 4'h5;
   endfunction
   // Parity mode: 0 off, 1 computed, 2 stuck zero, 3 stuck one.
   function automatic logic [1:0] ulc_pmode(input logic [7:0] lc);
      if (!lc[`ULC_LC_PEN]) begin
         ulc_pmode = 2'h0;
      end else if (!lc[`ULC_LC_SPS]) begin
         ulc_pmode = 2'h1;
      end else begin
         ulc_pmode = lc[`ULC_LC_EPS] ? 2'h2 : 2'h3;
      end
   endfunction
   // Parity bit that completes the frame for the selected sense.
   function automatic logic ulc_pbit(input logic [7:0] d,
                                     input logic [3:0] n,
                                     input logic [1:0] m,
                                     input logic even);
      logic x;
      x = ^(d & (8'hFF >> (4'h8 - n)));
      case (m)
         2'h2:    ulc_pbit = 1'b0;
         2'h3:    ulc_pbit = 1'b1;
         default: ulc_pbit = even ? x : ~x;
      endcase
   endfunction

   // AHB-Lite address phase capture; slave is always ready and OKAY.
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         dp_wr     <= 1'b0;
         dp_rd     <= 1'b0;
         dp_addr   <= 12'h000;
         HREADYOUT <= 1'b1;
         HRESP     <= 1'b0;
      end else begin
         dp_wr     <= bus_go && HWRITE;
         dp_rd     <= bus_go && !HWRITE;
         dp_addr   <= HADDR;
         HREADYOUT <= 1'b1;
         HRESP     <= 1'b0;
      end
   end

   // Control registers; reset leaves only the section enables set.
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         line_control       <= `ULC_LCTL_RST;
         module_control     <= `ULC_MCTL_RST;
         integer_divisor    <= `ULC_IBRD_RST;
         fractional_divisor <= `ULC_FBRD_RST;
      end else if (dp_wr) begin
         case (dp_addr)
            `ULC_OFS_LCTL: line_control <= HWDATA[7:0];
            `ULC_OFS_MCTL: module_control <= HWDATA[9:0] & 10'h301;
            `ULC_OFS_IBRD: integer_divisor <= HWDATA[15:0];
            `ULC_OFS_FBRD: fractional_divisor <= HWDATA[5:0];
            default: ;
         endcase
      end
   end

   // Divisors load only on a line control write: never half-written.
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         act_int  <= `ULC_IBRD_RST;
         act_frac <= `ULC_FBRD_RST;
      end else if (wr_lc) begin
         act_int  <= integer_divisor;
         act_frac <= fractional_divisor;
      end
   end

   // Read mux, registered so that data stands in the data phase.
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         HRDATA <= 32'h0000_0000;
      end else if (bus_go && !HWRITE) begin
         case (HADDR)
            `ULC_OFS_LCTL: HRDATA <= {24'h000000, line_control};
            `ULC_OFS_MCTL: HRDATA <= {22'h000000, module_control};
            `ULC_OFS_IBRD: HRDATA <= {16'h0000, integer_divisor};
            `ULC_OFS_FBRD: HRDATA <= {26'h0000000, fractional_divisor};
            `ULC_OFS_DATA: HRDATA <= {22'h000000, err_pe, err_fe,
                                      rx_mem[rx_rp]};
            `ULC_OFS_STAT: HRDATA <= {24'h000000, tx_cnt == 0, rx_full,
                                      tx_full, rx_cnt == 0,
                                      tx_cnt != 0 || tx_state != ULC_IDLE,
                                      3'h0};
            default:       HRDATA <= 32'h0000_0000;
         endcase
      end
   end

   // Transmit buffer; writes to a full buffer are dropped.
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         tx_wp <= '0;
      end else if (wr_dat && !tx_full) begin
         tx_mem[tx_wp] <= HWDATA[7:0];
         tx_wp         <= tx_wp + 1'b1;
      end
   end

   // Transmit count and read pointer.
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         tx_cnt <= '0;
         tx_rp  <= '0;
      end else begin
         tx_cnt <= tx_cnt + ($clog2(DEPTH)+1)'(wr_dat && !tx_full)
                   - ($clog2(DEPTH)+1)'(tx_state == ULC_IDLE && run_tx
                        && !line_control[`ULC_LC_BRK] && tx_cnt != 0);
         if (tx_state == ULC_IDLE && run_tx
             && !line_control[`ULC_LC_BRK] && tx_cnt != 0) begin
            tx_rp <= tx_rp + 1'b1;
         end
      end
   end

   // Transmit framer. The format is latched at the start bit, and the
   // enables are only looked at in idle, so a character always ends.
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         tx_state      <= ULC_IDLE;
         SERIAL_TX_PIN <= 1'b1;
         tx_shift      <= 8'h00;
         tx_bit        <= 3'h0;
         tx_par        <= 1'b0;
         tx_fmt_nbits  <= 4'h5;
         tx_fmt_par    <= 2'h0;
         tx_fmt_two_stop_select   <= 1'b0;
         tx_stop2nd    <= 1'b0;
         tx_tick       <= 22'h000000;
      end else begin
         tx_tick <= (tx_state == ULC_IDLE || tx_state == ULC_BREAK
                     || tx_bdone) ? 22'h000000 : tx_tick + 22'h000001;
         case (tx_state)
            ULC_IDLE: begin
               if (line_control[`ULC_LC_BRK]) begin
                  tx_state      <= ULC_BREAK;
                  SERIAL_TX_PIN <= 1'b0;
               end else if (run_tx && tx_cnt != 0) begin
                  tx_state     <= ULC_START;
                  SERIAL_TX_PIN <= 1'b0;
                  tx_shift     <= tx_mem[tx_rp];
                  tx_fmt_nbits <= ulc_nbits(line_control[6:5]);
                  tx_fmt_par   <= ulc_pmode(line_control);
                  tx_fmt_two_stop_select  <= line_control[`ULC_LC_TWO_STOP_SELECT];
                  tx_par       <= ulc_pbit(tx_mem[tx_rp],
                                     ulc_nbits(line_control[6:5]),
                                     ulc_pmode(line_control),
                                     line_control[`ULC_LC_EPS]);
                  tx_bit       <= 3'h0;
               end else begin
                  SERIAL_TX_PIN <= 1'b1;
               end
            end
            ULC_START: begin
               if (tx_bdone) begin
                  tx_state      <= ULC_DATA;
                  SERIAL_TX_PIN <= tx_shift[0];
               end
            end
            ULC_DATA: begin
               if (tx_bdone) begin
                  tx_shift <= {1'b0, tx_shift[7:1]};
                  tx_bit   <= tx_bit + 3'h1;
                  if (4'(tx_bit) + 4'h1 < tx_fmt_nbits) begin
                     SERIAL_TX_PIN <= tx_shift[1];
                  end else if (tx_fmt_par != 2'h0) begin
                     tx_state      <= ULC_PAR;
                     SERIAL_TX_PIN <= tx_par;
                  end else begin
                     tx_state      <= ULC_STOP;
                     SERIAL_TX_PIN <= 1'b1;
                     tx_stop2nd    <= 1'b0;
                  end
               end
            end
            ULC_PAR: begin
               if (tx_bdone) begin
                  tx_state      <= ULC_STOP;
                  SERIAL_TX_PIN <= 1'b1;
                  tx_stop2nd    <= 1'b0;
               end
            end
            ULC_STOP: begin
               if (tx_bdone) begin
                  if (tx_fmt_two_stop_select && !tx_stop2nd) begin
                     tx_stop2nd <= 1'b1;
                  end else begin
                     tx_state <= ULC_IDLE;
                  end
               end
            end
            ULC_BREAK: begin
               if (!line_control[`ULC_LC_BRK]) begin
                  tx_state      <= ULC_IDLE;
                  SERIAL_TX_PIN <= 1'b1;
               end else begin
                  SERIAL_TX_PIN <= 1'b0;
               end
            end
            default: tx_state <= ULC_IDLE;
         endcase
      end
   end

   // Receive pin synchroniser.
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         rx_s1 <= 1'b1;
         rx_s2 <= 1'b1;
      end else begin
         rx_s1 <= SERIAL_RX_PIN;
         rx_s2 <= rx_s1;
      end
   end

   // Receive framer. Sampling is at mid-bit; only the first stop bit
   // is checked, so two-stop senders are accepted as well.
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         rx_state     <= ULC_IDLE;
         rx_shift     <= 8'h00;
         rx_bit       <= 3'h0;
         rx_fmt_nbits <= 4'h5;
         rx_fmt_par   <= 2'h0;
         rx_fmt_pen   <= 1'b0;
         rx_par_err   <= 1'b0;
         rx_tick      <= 22'h000000;
         rx_wp        <= '0;
         err_pe       <= 1'b0;
         err_fe       <= 1'b0;
      end else begin
         rx_tick <= (rx_state == ULC_IDLE || rx_bdone) ? 22'h000000
                    : rx_tick + 22'h000001;
         case (rx_state)
            ULC_IDLE: begin
               if (run_rx && !rx_s2) begin
                  rx_state     <= ULC_START;
                  rx_tick      <= {1'b0, bit_len[21:1]};
                  rx_bit       <= 3'h0;
                  rx_shift     <= 8'h00;
                  rx_fmt_nbits <= ulc_nbits(line_control[6:5]);
                  rx_fmt_par   <= ulc_pmode(line_control);
                  rx_fmt_pen   <= line_control[`ULC_LC_EPS];
               end
            end
            ULC_START: begin
               if (rx_bdone) begin
                  rx_state <= rx_s2 ? ULC_IDLE : ULC_DATA;
               end
            end
            ULC_DATA: begin
               if (rx_bdone) begin
                  rx_shift[rx_bit] <= rx_s2;
                  rx_bit <= rx_bit + 3'h1;
                  if (4'(rx_bit) + 4'h1 >= rx_fmt_nbits) begin
                     rx_state <= rx_fmt_par != 2'h0 ? ULC_PAR : ULC_STOP;
                  end
               end
            end
            ULC_PAR: begin
               if (rx_bdone) begin
                  rx_state   <= ULC_STOP;
                  rx_par_err <= rx_s2 != ulc_pbit(rx_shift, rx_fmt_nbits,
                                   rx_fmt_par, rx_fmt_pen);
               end
            end
            ULC_STOP: begin
               if (rx_bdone) begin
                  rx_state   <= ULC_IDLE;
                  rx_par_err <= 1'b0;
                  if (!rx_full) begin
                     rx_mem[rx_wp] <= rx_shift;
                     rx_wp  <= rx_wp + 1'b1;
                     err_pe <= rx_par_err && rx_fmt_par != 2'h0;
                     err_fe <= !rx_s2;
                  end
               end
            end
            default: rx_state <= ULC_IDLE;
         endcase
      end
   end

   // Receive count and read pointer; a read of an empty buffer is a no-op.
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         rx_cnt <= '0;
         rx_rp  <= '0;
      end else begin
         rx_cnt <= rx_cnt + ($clog2(DEPTH)+1)'(rx_state == ULC_STOP
                     && rx_bdone && !rx_full)
                   - ($clog2(DEPTH)+1)'(rd_dat && rx_cnt != 0);
         if (rd_dat && rx_cnt != 0) begin
            rx_rp <= rx_rp + 1'b1;
         end
      end
   end
endmodule

// ===== hdl/ulc_defs.svh
`ifndef ULC_DEFS_SVH
`define ULC_DEFS_SVH
// Register byte offsets.
`define ULC_OFS_IBRD    12'h024
`define ULC_OFS_FBRD    12'h028
`define ULC_OFS_LCTL    12'h02C
`define ULC_OFS_MCTL    12'h030
`define ULC_OFS_DATA    12'h000
`define ULC_OFS_STAT    12'h018
// Line control fields.
`define ULC_LC_BRK      0
`define ULC_LC_PEN      1
`define ULC_LC_EPS      2
`define ULC_LC_TWO_STOP_SELECT     3
`define ULC_LC_FEN      4
`define ULC_LC_WLO      5
`define ULC_LC_SPS      7
// Module control fields.
`define ULC_MC_EN       0
`define ULC_MC_TXE      8
`define ULC_MC_RXE      9
// Reset values.
`define ULC_LCTL_RST    8'h00
`define ULC_MCTL_RST    10'h300
`define ULC_IBRD_RST    16'h0000
`define ULC_FBRD_RST    6'h00
// Status bits.
`define ULC_ST_PE       0
`define ULC_ST_FE       1
`define ULC_ST_BUSY     3
`define ULC_ST_RXFE     4
`define ULC_ST_TXFF     5
`define ULC_ST_RXFF     6
`define ULC_ST_TXFE     7
`endif

// ===== hdl/ulc_pkg.sv
package ulc_pkg;
   typedef enum logic [2:0] {ULC_IDLE, ULC_START, ULC_DATA, ULC_PAR,
                             ULC_STOP, ULC_BREAK} ulc_state_type;
endpackage

// ===== verif/ulc_uart_props.sv
`timescale 1ns/1ns
`include "ulc_defs.svh"
module ulc_uart_props (
   input wire logic        CORE_CLK,
   input wire logic        RST,
   input wire logic        HSEL,
   input wire logic [11:0] HADDR,
   input wire logic [1:0]  HTRANS,
   input wire logic        HWRITE,
   input wire logic [31:0] HWDATA,
   input wire logic        HREADY,
   input wire logic [31:0] HRDATA,
   input wire logic        HREADYOUT,
   input wire logic        HRESP,
   input wire logic        SERIAL_TX_PIN
);
   logic        wr_ph;
   logic [11:0] ph_addr;
   logic [7:0]  lc;
   logic [9:0]  mc;
   logic [7:0]  hi_cnt;
   logic        rd_go;
   // A read is taken on a selected, ready, non-idle read transfer.
   assign rd_go = HSEL & HREADY & HTRANS[1] & !HWRITE;
   // Shadow copies of the control registers, built from bus writes.
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         wr_ph <= 1'b0;
         ph_addr <= 12'h000;
         lc <= `ULC_LCTL_RST;
         mc <= `ULC_MCTL_RST;
      end else begin
         wr_ph <= HSEL & HREADY & HTRANS[1] & HWRITE;
         ph_addr <= HADDR;
         if (wr_ph && ph_addr == `ULC_OFS_LCTL) lc <= HWDATA[7:0];
         if (wr_ph && ph_addr == `ULC_OFS_MCTL) mc <= HWDATA[9:0] & 10'h301;
      end
   end
   // High run length; it saturates so a quiet line stays recognisable.
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) hi_cnt <= 8'h00;
      else if (!SERIAL_TX_PIN) hi_cnt <= 8'h00;
      else if (hi_cnt != 8'hFF) hi_cnt <= hi_cnt + 8'h01;
   end
   default clocking @(posedge CORE_CLK);
   endclocking
   default disable iff (RST);
   property p_bus;
      HREADYOUT && !HRESP;
   endproperty
   a_bus: assert property (p_bus) else $error("bus answer not ready okay");
   property p_tx_rst;
      $fell(RST) |-> SERIAL_TX_PIN;
   endproperty
   a_tx_rst: assert property (p_tx_rst) else $error("line not idle");
   property p_hold;
      !$past(rd_go) |-> $stable(HRDATA);
   endproperty
   a_hold: assert property (p_hold) else $error("read data moved");
   property p_lc_rd;
      rd_go && HADDR == `ULC_OFS_LCTL |=> HRDATA == {24'h000000, lc};
   endproperty
   a_lc_rd: assert property (p_lc_rd) else $error("line control read");
   property p_mc_rd;
      rd_go && HADDR == `ULC_OFS_MCTL |=> HRDATA == {22'h000000, mc};
   endproperty
   a_mc_rd: assert property (p_mc_rd) else $error("module ctl read");
   property p_start;
      $fell(SERIAL_TX_PIN) |-> !SERIAL_TX_PIN [*8];
   endproperty
   a_start: assert property (p_start) else $error("start bit short");
   property p_idle;
      !mc[0] && !lc[0] && hi_cnt > 8'h78 |=> SERIAL_TX_PIN;
   endproperty
   a_idle: assert property (p_idle) else $error("sent while off");
   property p_brk;
      $rose(lc[0]) && mc[0] |-> ##[1:130] !SERIAL_TX_PIN;
   endproperty
   a_brk: assert property (p_brk) else $error("break not driven");
endmodule

// ===== verif/ulc_remote.sv
`timescale 1ns/1ns
module ulc_remote #(
   parameter int BIT = 9
) (
   input  wire logic clk,
   input  wire logic line_in,
   output logic      line_out
);
   // The far line idles high, as an unused serial line does.
   initial line_out = 1'b1;
   // Samples the start bit and n further bits at their middles.
   task automatic recv(input int n, output logic [12:0] bits, output time t);
      bits = 13'h1FFF;
      while (line_in !== 1'b0) @(posedge clk);
      t = $time;
      repeat (BIT / 2) @(posedge clk);
      for (int i = 0; i <= n; i++) begin
         bits[i] = line_in;
         if (i < n) repeat (BIT) @(posedge clk);
      end
   endtask
   // Sends start, then n bits least significant first, one stop only.
   task automatic send(input int n, input logic [11:0] bits);
      line_out <= 1'b0;
      repeat (BIT) @(posedge clk);
      for (int i = 0; i < n; i++) begin
         line_out <= bits[i];
         repeat (BIT) @(posedge clk);
      end
      line_out <= 1'b1;
   endtask
endmodule

// ===== verif/uart_line_control_bench.sv
`timescale 1ns/1ns
`include "ulc_defs.svh"
module uart_line_control_bench;
   localparam int BIT = 9;
   logic        clk, rst, hsel, hwrite, hready, hreadyout, hresp, rxd, txd;
   logic [11:0] haddr;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [31:0] hwdata, hrdata, x;
   integer      seed;
   int          fail_count, checks, w, n;
   logic [7:0]  c, d0, d1, m;
   logic [12:0] f;
   logic [11:0] s;
   logic        pe, fe;
   time         t0, t1;
   ulc_uart #(.DEPTH(16)) u_dut (.CORE_CLK(clk), .RST(rst), .HSEL(hsel),
      .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize),
      .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata),
      .HREADYOUT(hreadyout), .HRESP(hresp), .SERIAL_RX_PIN(rxd),
      .SERIAL_TX_PIN(txd));
   ulc_remote #(.BIT(BIT)) u_far (.clk(clk), .line_in(txd), .line_out(rxd));
   // The single slave's ready is the bus ready.
   assign hready = hreadyout;
   always #2 clk = ~clk;
   task check(input string what, input logic [31:0] got, logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task print_verdict;
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // One single word transfer: address phase, then data phase.
   task automatic bus(input logic wt, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] r);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= wt;
      do @(posedge clk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      do @(posedge clk); while (hready !== 1'b1);
      r = hrdata;
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d);
      bus(1'b1, a, d, x);
   endtask
   task rd(input string what, input logic [11:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0, x);
      check(what, x, e);
   endtask
   function automatic logic par(logic [7:0] cf, logic [7:0] d);
      if (cf[7]) return !cf[2];
      return cf[2] ? ^(d & (8'hFF >> (3 - cf[6:5])))
                   : ~^(d & (8'hFF >> (3 - cf[6:5])));
   endfunction
   // Whole frame as the line shows it: start, data, parity, stops high.
   function automatic logic [12:0] frame(logic [7:0] cf, logic [7:0] d);
      logic [12:0] fr;
      fr = 13'h1FFE;
      for (int i = 0; i < 5 + cf[6:5]; i++) fr[i + 1] = d[i];
      if (cf[1]) fr[6 + cf[6:5]] = par(cf, d);
      return fr;
   endfunction
   function automatic int nb(logic [7:0] cf);
      return 6 + cf[6:5] + cf[1] + cf[3];
   endfunction
   initial begin
      repeat (60000) @(posedge clk);
      fail_count++;
      print_verdict;
   end
   initial begin
      clk = 1'b0;
      rst = 1'b1;
      hsel = 1'b0;
      haddr = 12'h000;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      seed = 32'hB761AD7E;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      rd("line control", `ULC_OFS_LCTL, 32'h0);
      rd("module control", `ULC_OFS_MCTL, 32'h300);
      rd("unmapped", 12'h040, 32'h0);
      wr(`ULC_OFS_MCTL, 32'hFFFFFFFF);
      rd("control bits", `ULC_OFS_MCTL, 32'h301);
      wr(`ULC_OFS_MCTL, 32'h300);
      wr(`ULC_OFS_IBRD, 32'h0);
      wr(`ULC_OFS_FBRD, BIT - 1);
      // Random formats; the low two loop bits sweep every word length.
      for (int k = 0; k < 16; k++) begin
         c = 8'($random(seed));
         c[6:5] = k[1:0];
         c[0] = 1'b0;
         d0 = 8'($random(seed));
         d1 = 8'($random(seed));
         w = 5 + c[6:5];
         m = 8'hFF >> (3 - c[6:5]);
         wr(`ULC_OFS_MCTL, 32'h300);
         wr(`ULC_OFS_LCTL, 32'(c));
         wr(`ULC_OFS_DATA, 32'(d0));
         if (c[4]) wr(`ULC_OFS_DATA, 32'(d1));
         bus(1'b0, `ULC_OFS_STAT, 32'h0, x);
         check("tx full", 32'(x[5]), 32'(!c[4]));
         fork
            u_far.recv(nb(c), f, t0);
            wr(`ULC_OFS_MCTL, 32'h301);
         join
         check("tx frame", 32'(f), 32'(frame(c, d0)));
         if (c[4]) begin
            u_far.recv(nb(c), f, t1);
            check("tx frame 2", 32'(f), 32'(frame(c, d1)));
            check("frame gap", 32'(((t1 - t0) / 4 - (nb(c) + 1) * BIT) <= 2),
                  32'h1);
         end
         pe = c[1] & d1[0];
         fe = d1[1] & d1[2];
         s = 12'(frame(c, d0 | {7'h0, fe}) >> 1);
         n = w + c[1] + 1;
         if (pe) s[w] = !s[w];
         if (fe) s[n - 1] = 1'b0;
         u_far.send(n, s);
         repeat (2 * BIT) @(posedge clk);
         rd("rx word", `ULC_OFS_DATA,
            {22'h0, pe, fe, (d0 | {7'h0, fe}) & m});
      end
      // Disable in mid-frame: the character must still go out whole.
      wr(`ULC_OFS_DATA, 32'(d1));
      fork
         u_far.recv(nb(c), f, t0);
         begin
            repeat (4 * BIT) @(posedge clk);
            wr(`ULC_OFS_MCTL, 32'h300);
         end
      join
      check("frame after off", 32'(f), 32'(frame(c, d1)));
      // Break requested in mid-frame waits for the frame to end.
      wr(`ULC_OFS_MCTL, 32'h301);
      wr(`ULC_OFS_DATA, 32'(d0));
      fork
         u_far.recv(nb(c), f, t0);
         begin
            repeat (2 * BIT) @(posedge clk);
            wr(`ULC_OFS_LCTL, 32'(c | 8'h01));
         end
      join
      check("frame before break", 32'(f), 32'(frame(c, d0)));
      repeat (3 * nb(c) * BIT) @(posedge clk);
      check("break level", 32'(txd), 32'h0);
      wr(`ULC_OFS_LCTL, 32'(c));
      repeat (BIT) @(posedge clk);
      check("after break", 32'(txd), 32'h1);
      print_verdict;
   end
endmodule
bind ulc_uart ulc_uart_props u_props (.CORE_CLK(CORE_CLK), .RST(RST),
   .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
   .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA),
   .HREADYOUT(HREADYOUT), .HRESP(HRESP), .SERIAL_TX_PIN(SERIAL_TX_PIN));
